// [common/pmx_regs.svh]
`ifndef PMX_REGS_SVH
`define PMX_REGS_SVH

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define PMX_NPIN 21
`define PMX_NCODE 32
`define PMX_ADDR_W 8
`define PMX_DATA_W 32
`define PMX_REG_W 8

// ----------------------------------------------------------------
// control register fields and reset value
// ----------------------------------------------------------------
`define PMX_SEL_MSB 4
`define PMX_SEL_LSB 0
`define PMX_RSVD_BIT 5
`define PMX_IDX_MSB 6
`define PMX_IDX_LSB 2
`define PMX_IRQ_BIT 6
`define PMX_ANALOG_SELECT_BIT 7
`define PMX_CTRL_RESET 8'h00
`define PMX_SEL_HIZ 5'h00

// ----------------------------------------------------------------
// register indices, byte address is index times four
// ----------------------------------------------------------------
`define PMX_IDX_B1 5'h00
`define PMX_IDX_C2 5'h01
`define PMX_IDX_C3 5'h02
`define PMX_IDX_C4 5'h03
`define PMX_IDX_C5 5'h04
`define PMX_IDX_C6 5'h05
`define PMX_IDX_C7 5'h06
`define PMX_IDX_D 5'h07
`define PMX_IDX_E0 5'h08
`define PMX_IDX_E1 5'h09
`define PMX_IDX_E2 5'h0a
`define PMX_IDX_E3 5'h0b
`define PMX_IDX_E4 5'h0c
`define PMX_IDX_E5 5'h0d
`define PMX_IDX_H0 5'h0e
`define PMX_IDX_H1 5'h0f
`define PMX_IDX_H2 5'h10
`define PMX_IDX_H3 5'h11
`define PMX_IDX_J1 5'h12
`define PMX_IDX_J6 5'h13
`define PMX_IDX_J7 5'h14

// ----------------------------------------------------------------
// defined select codes per pin, one bit per code
// ----------------------------------------------------------------
`define PMX_MASK_B1 32'h02010826
`define PMX_MASK_C2 32'h02002402
`define PMX_MASK_C3 32'h02000400
`define PMX_MASK_C4 32'h02002cae
`define PMX_MASK_C5 32'h0200242c
`define PMX_MASK_C6 32'h02002402
`define PMX_MASK_C7 32'h0a0024a6
`define PMX_MASK_D 32'h00000000
`define PMX_MASK_E0 32'h00001000
`define PMX_MASK_E1 32'h00001002
`define PMX_MASK_E2 32'h02001002
`define PMX_MASK_E3 32'h02001286
`define PMX_MASK_E4 32'h0200020e
`define PMX_MASK_E5 32'h00010006
`define PMX_MASK_H0 32'h02000082
`define PMX_MASK_H1 32'h02000022
`define PMX_MASK_H2 32'h02000022
`define PMX_MASK_H3 32'h02000022
`define PMX_MASK_J 32'h00000000

// ----------------------------------------------------------------
// pins owning interrupt and analog select bits
// ----------------------------------------------------------------
`define PMX_IRQ_CAP 21'h002401
`define PMX_ANALOG_SELECT_CAP 21'h183f00
`define PMX_IRQ_LINES 8
`define PMX_IRQ_LINE_B1 4
`define PMX_IRQ_LINE_E2 7
`define PMX_IRQ_LINE_E5 5
`define PMX_ADC_CH 6

`endif

// [common/pmx_pkg.sv]
package pmx_pkg;

	typedef logic [4:0] pmx_sel_t;
	typedef logic [7:0] pmx_ctrl_t;
	typedef logic [31:0] pmx_code_mask_t;

endpackage : pmx_pkg

// [logic/pmx_port_mux.sv]
// Operation
// [RULE1] five-bit select per pin; code zero leaves pin undriven, nothing connected
// [RULE2] interrupt select one feeds the pin to its interrupt line, zero blocks it
// [RULE3] interrupt select on B1 line 4, E2 line 7, E5 line 5; none on C
// [RULE4] analog select one hands pin to analog block, zero keeps it digital
// [RULE5] E0..E5 reach converter 16..21; E1, E2, E4 also reach comparator nodes
// [RULE6] C4 codes route its nine timer, serial, spi and sense functions
// [RULE7] E3 codes route its six timer, disable, clock, flow and sense functions
// [RULE8] C7 codes route its eight timer, ref, serial, spi, sense, lowpower functions
// [RULE9] H0 routes only codes 1, 7 and 25; others are undefined
// [RULE10] E1 routes timer_io_4c at code 1 and ser_tx_12 at code 12
// [RULE11] software writes only defined codes; undefined codes act as high-impedance
`include "pmx_regs.svh"

module pmx_port_mux
	import pmx_pkg::*;
#(
	parameter int NPIN = `PMX_NPIN
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`PMX_ADDR_W-1:0] paddr,
	input wire logic [`PMX_DATA_W-1:0] pwdata,
	output logic [`PMX_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NPIN-1:0] pad_in,
	output logic [NPIN-1:0] pad_out,
	output logic [NPIN-1:0] pad_oe,
	input wire logic [NPIN-1:0][`PMX_NCODE-1:0] fn_out,
	input wire logic [NPIN-1:0][`PMX_NCODE-1:0] fn_oe,
	output logic [NPIN-1:0][`PMX_NCODE-1:0] fn_in,
	output logic [`PMX_IRQ_LINES-1:0] irq_line,
	output logic [`PMX_ADC_CH-1:0] adc_in_sel,
	output logic cmp_b0_a_sel,
	output logic cmp_ref_b0_sel,
	output logic cmp_a2_b_sel,
	output logic vref_hi_sel,
	output logic vref_lo_sel,
	output logic [NPIN-1:0] pin_analog_select,
	output logic [NPIN-1:0] pin_irq_input_select
);

	// ----------------------------------------------------------------
	// per-pin tables
	// ----------------------------------------------------------------
	localparam pmx_code_mask_t FN_MASK [`PMX_NPIN] = '{
		`PMX_MASK_B1, `PMX_MASK_C2, `PMX_MASK_C3, `PMX_MASK_C4, `PMX_MASK_C5,
		`PMX_MASK_C6, `PMX_MASK_C7, `PMX_MASK_D, `PMX_MASK_E0, `PMX_MASK_E1,
		`PMX_MASK_E2, `PMX_MASK_E3, `PMX_MASK_E4, `PMX_MASK_E5, `PMX_MASK_H0,
		`PMX_MASK_H1, `PMX_MASK_H2, `PMX_MASK_H3, `PMX_MASK_J, `PMX_MASK_J,
		`PMX_MASK_J
	};
	localparam logic [`PMX_NPIN-1:0] IRQ_CAP = `PMX_IRQ_CAP;
	localparam logic [`PMX_NPIN-1:0] ANALOG_SELECT_CAP = `PMX_ANALOG_SELECT_CAP;

	pmx_ctrl_t ctrl_q [NPIN];
	logic [`PMX_DATA_W-1:0] prdata_q;
	logic [4:0] reg_idx;
	logic addr_hit;
	logic wr_strobe;
	logic [NPIN-1:0] code_ok;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	assign reg_idx = paddr[`PMX_IDX_MSB:`PMX_IDX_LSB];
	always_comb
	begin
		if (paddr[`PMX_IDX_LSB-1:0] != 2'h0)
			addr_hit = 1'b0;
		else if (paddr[`PMX_ADDR_W-1] != 1'b0)
			addr_hit = 1'b0;
		else if (int'(reg_idx) < NPIN)
			addr_hit = 1'b1;
		else
			addr_hit = 1'b0;
	end

	// zero wait states; unmapped words answer with an error and no effect
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_hit;
	assign wr_strobe = psel & penable & pwrite & addr_hit;
	assign prdata = prdata_q;

	// read data is captured in the setup cycle so it leaves a flip-flop
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_q <= 32'h00000000;
		else if (psel & ~penable)
		begin
			if (addr_hit & ~pwrite)
				prdata_q <= {24'h000000, ctrl_q[reg_idx]};
			else
				prdata_q <= 32'h00000000;
		end
	end

	// ----------------------------------------------------------------
	// per-pin control register and mux
	// ----------------------------------------------------------------
	genvar p;
	generate
		for (p = 0; p < NPIN; p++)
		begin : g_pin
			pmx_sel_t sel;
			logic routed;

			// bits a pin does not own stay zero and read as zero
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					ctrl_q[p] <= `PMX_CTRL_RESET;
				else if (wr_strobe && int'(reg_idx) == p)
				begin
					ctrl_q[p][`PMX_SEL_MSB:`PMX_SEL_LSB] <= pwdata[`PMX_SEL_MSB:`PMX_SEL_LSB]; // [RULE1]
					ctrl_q[p][`PMX_RSVD_BIT] <= 1'b0;
					ctrl_q[p][`PMX_IRQ_BIT] <= pwdata[`PMX_IRQ_BIT] & IRQ_CAP[p]; // [RULE3]
					ctrl_q[p][`PMX_ANALOG_SELECT_BIT] <= pwdata[`PMX_ANALOG_SELECT_BIT] & ANALOG_SELECT_CAP[p]; // [RULE4]
				end
			end

			assign sel = ctrl_q[p][`PMX_SEL_MSB:`PMX_SEL_LSB];
			assign pin_irq_input_select[p] = ctrl_q[p][`PMX_IRQ_BIT];
			assign pin_analog_select[p] = ctrl_q[p][`PMX_ANALOG_SELECT_BIT];

			// undefined codes, code zero and analog use all leave the pin floating
			assign code_ok[p] = FN_MASK[p][sel] && sel != `PMX_SEL_HIZ; // [RULE11]
			assign routed = code_ok[p] & ~pin_analog_select[p]; // [RULE1] [RULE4]
			assign pad_out[p] = routed & fn_out[p][sel]; // [RULE6] [RULE7] [RULE8] [RULE9] [RULE10]
			assign pad_oe[p] = routed & fn_oe[p][sel];

			always_comb
			begin
				fn_in[p] = 32'h00000000;
				if (routed)
					fn_in[p][sel] = pad_in[p];
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// external interrupt inputs
	// ----------------------------------------------------------------
	always_comb
	begin
		irq_line = 8'h00;
		irq_line[`PMX_IRQ_LINE_B1] = pin_irq_input_select[`PMX_IDX_B1] & pad_in[`PMX_IDX_B1]; // [RULE2] [RULE3]
		irq_line[`PMX_IRQ_LINE_E2] = pin_irq_input_select[`PMX_IDX_E2] & pad_in[`PMX_IDX_E2]; // [RULE2] [RULE3]
		irq_line[`PMX_IRQ_LINE_E5] = pin_irq_input_select[`PMX_IDX_E5] & pad_in[`PMX_IDX_E5]; // [RULE2] [RULE3]
	end

	// ----------------------------------------------------------------
	// analog connections
	// ----------------------------------------------------------------
	// adc_in_sel bit k is converter input 16+k
	assign adc_in_sel = pin_analog_select[`PMX_IDX_E5:`PMX_IDX_E0]; // [RULE5]
	assign cmp_b0_a_sel = pin_analog_select[`PMX_IDX_E1]; // [RULE5]
	assign cmp_ref_b0_sel = pin_analog_select[`PMX_IDX_E2]; // [RULE5]
	assign cmp_a2_b_sel = pin_analog_select[`PMX_IDX_E4]; // [RULE5]
	assign vref_hi_sel = pin_analog_select[`PMX_IDX_J6]; // [RULE4]
	assign vref_lo_sel = pin_analog_select[`PMX_IDX_J7]; // [RULE4]

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_hiz_code_float: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
		(ctrl_q[`PMX_IDX_C4][`PMX_SEL_MSB:`PMX_SEL_LSB] == `PMX_SEL_HIZ)
		|-> (pad_oe[`PMX_IDX_C4] == 1'b0 && fn_in[`PMX_IDX_C4] == 32'h00000000))
		else $error("pin c4 not floating with code zero");

	chk_irq_gate_b1: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
		(wr_strobe && reg_idx == `PMX_IDX_B1)
		|=> irq_line[`PMX_IRQ_LINE_B1] == ($past(pwdata[`PMX_IRQ_BIT]) & pad_in[`PMX_IDX_B1]))
		else $error("interrupt line 4 not gated by b1 select");

	chk_irq_unused: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
		(irq_line & 8'h4f) == 8'h00)
		else $error("an unassigned interrupt line is active");

	chk_port_d_float: assert property (@(posedge pclk) disable iff (!presetn) // [RULE11]
		pad_oe[`PMX_IDX_D] == 1'b0 && fn_in[`PMX_IDX_D] == 32'h00000000)
		else $error("port d connected a function with no defined code");

	chk_irq_port_c: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
		(wr_strobe && reg_idx == `PMX_IDX_C5 && pwdata[`PMX_IRQ_BIT])
		|=> !pin_irq_input_select[`PMX_IDX_C5])
		else $error("port c gained an interrupt select bit");

	chk_analog_release: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
		(wr_strobe && reg_idx == `PMX_IDX_E3 && pwdata[`PMX_ANALOG_SELECT_BIT])
		|=> (pad_oe[`PMX_IDX_E3] == 1'b0 && adc_in_sel[3]) [*2])
		else $error("analog pin e3 still driven digitally");

	chk_cmp_e4_link: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
		(wr_strobe && reg_idx == `PMX_IDX_E4)
		|=> (cmp_a2_b_sel == $past(pwdata[`PMX_ANALOG_SELECT_BIT]) && adc_in_sel[4] == cmp_a2_b_sel))
		else $error("comparator input not tied to e4 analog select");

	chk_c4_route: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
		(ctrl_q[`PMX_IDX_C4] == 8'h0b) |-> (pad_oe[`PMX_IDX_C4] == fn_oe[`PMX_IDX_C4][11]))
		else $error("c4 code 11 not routed to flow_ctl_8");

	chk_c7_route: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
		(ctrl_q[`PMX_IDX_C7] == 8'h1b) |-> (pad_out[`PMX_IDX_C7] == fn_out[`PMX_IDX_C7][27]))
		else $error("c7 code 27 not routed to lowpower_timer_out");

	chk_h0_undefined: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
		(wr_strobe && reg_idx == `PMX_IDX_H0 && pwdata[4:0] == 5'h02)
		|=> (pad_oe[`PMX_IDX_H0] == 1'b0 && fn_in[`PMX_IDX_H0] == 32'h00000000))
		else $error("h0 undefined code connected a function");

	chk_e1_route: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
		(ctrl_q[`PMX_IDX_E1] == 8'h0c) |-> (pad_out[`PMX_IDX_E1] == fn_out[`PMX_IDX_E1][12]))
		else $error("e1 code 12 not routed to ser_tx_12");

	chk_e3_readback: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
		(wr_strobe && reg_idx == `PMX_IDX_E3)
		|=> ctrl_q[`PMX_IDX_E3][`PMX_SEL_MSB:`PMX_SEL_LSB] == $past(pwdata[4:0]))
		else $error("e3 select field did not take the write");

endmodule : pmx_port_mux

// [testbench/tb_pmx_port_mux.sv]
`include "pmx_regs.svh"

module tb_pmx_port_mux import pmx_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [20:0] pad_in = '0;
	logic [20:0] pad_out;
	logic [20:0] pad_oe;
	logic [20:0][31:0] fn_out = '0;
	logic [20:0][31:0] fn_oe = '0;
	logic [20:0][31:0] fn_in;
	logic [7:0] irq_line;
	logic [5:0] adc_in_sel;
	logic cmp_b0_a_sel;
	logic cmp_ref_b0_sel;
	logic cmp_a2_b_sel;
	logic vref_hi_sel;
	logic vref_lo_sel;
	logic [20:0] pin_analog_select;
	logic [20:0] pin_irq_input_select;
	pmx_ctrl_t ctrl_m [21] = '{default: 8'h00};
	logic [31:0] mask_m [21] = '{default: 32'h0};
	logic [32:0] exp_q [$];
	int n_errors = 0;
	int checks = 0;
	int cycles = 0;
	logic probe = 1'b0;
	int probe_p = 0;
	int probe_c = 0;
	int rp [5] = '{3, 11, 6, 14, 9};
	logic [7:0] bad [5] = '{8'h54, 8'h7c, 8'h8c, 8'h0d, 8'h0e};
	logic [20:0] acap = 21'h183f00;
	logic [20:0] icap = 21'h002401;

	always #50 pclk = ~pclk;

	pmx_port_mux pmx_port_mux_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .pad_in, .pad_out, .pad_oe, .fn_out, .fn_oe, .fn_in,
		.irq_line, .adc_in_sel, .cmp_b0_a_sel, .cmp_ref_b0_sel, .cmp_a2_b_sel, .vref_hi_sel,
		.vref_lo_sel, .pin_analog_select, .pin_irq_input_select);

	// ----------------------------------------------------------------
	// expectation and observation
	// ----------------------------------------------------------------
	function automatic logic [32:0] predict(int p, int c);
		logic [20:0] a;
		logic [20:0] i;
		logic [4:0] s;
		logic on;
		logic oe;
		for (int k = 0; k < 21; k++)
		begin
			a[k] = ctrl_m[k][7];
			i[k] = ctrl_m[k][6];
		end
		s = ctrl_m[p][4:0];
		on = (s != 5'h00) && mask_m[p][s] && !a[p];
		oe = on && fn_oe[p][s];
		return {9'h0, i[10] & pad_in[10], 1'b0, i[13] & pad_in[13], i[0] & pad_in[0], 4'h0,
			a[13:8], a[9], a[10], a[12], a[19], a[20], oe, oe & fn_out[p][s],
			on && (s == c) && pad_in[p], i[p], a[p]};
	endfunction : predict

	function automatic logic [32:0] observe(int p, int c);
		return {9'h0, irq_line, adc_in_sel, cmp_b0_a_sel, cmp_ref_b0_sel, cmp_a2_b_sel,
			vref_hi_sel, vref_lo_sel, pad_oe[p], pad_out[p] & pad_oe[p], fn_in[p][c],
			pin_irq_input_select[p], pin_analog_select[p]};
	endfunction : observe

	task automatic compare(input logic [32:0] got);
		logic [32:0] exp;
		exp = (exp_q.size() > 0) ? exp_q.pop_front() : ~got;
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask : compare

	always @(posedge pclk)
	begin
		if (presetn && psel && penable && pready && !pwrite)
			compare({pslverr, prdata});
		else if (presetn && probe)
			compare(observe(probe_p, probe_c));
	end

	// ----------------------------------------------------------------
	// drivers
	// ----------------------------------------------------------------
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int idx;
		logic ok;
		idx = a[6:2];
		ok = !a[7] && (a[1:0] == 2'b00) && (idx < 21);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		if (!wr)
			exp_q.push_back(ok ? {25'h0, ctrl_m[idx]} : {1'b1, 32'h0});
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		if (wr && ok)
			ctrl_m[idx] = {d[7] & acap[idx], d[6] & icap[idx], 1'b0, d[4:0]};
	endtask : apb

	task automatic look(int p, int c);
		@(posedge pclk);
		pad_in <= 21'($urandom());
		for (int k = 0; k < 21; k++)
		begin
			fn_out[k] <= $urandom();
			fn_oe[k] <= $urandom();
		end
		probe <= 1'b1;
		probe_p <= p;
		probe_c <= c;
		@(negedge pclk);
		exp_q.push_back(predict(p, c));
		@(posedge pclk);
		probe <= 1'b0;
	endtask : look

	task automatic restart();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		ctrl_m = '{default: 8'h00};
		for (int k = 0; k < 21; k++)
			apb(1'b0, 8'(k * 4), 32'h0);
		look(3, 0);
	endtask : restart

	task automatic end_sim();
		if (n_errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim

	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			n_errors++;
			end_sim();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		logic [31:0] d;
		void'($urandom(85293));
		mask_m[3] = 32'h02002cae;
		mask_m[11] = 32'h02001286;
		mask_m[6] = 32'h0a0024a6;
		mask_m[14] = 32'h02000082;
		mask_m[9] = 32'h00001002;
		restart();
		// every code on each pin with a listed code set
		for (int j = 0; j < 5; j++)
			for (int c = 0; c < 32; c++)
			begin
				d = $urandom();
				d[4:0] = c[4:0];
				apb(1'b1, 8'(rp[j] * 4), d);
				apb(1'b0, 8'(rp[j] * 4), 32'h0);
				look(rp[j], c);
			end
		// interrupt and analog selects on all pins
		for (int r = 0; r < 4; r++)
			for (int p = 0; p < 21; p++)
			begin
				d = $urandom();
				d[4:0] = 5'h00;
				apb(1'b1, 8'(p * 4), d);
				apb(1'b0, 8'(p * 4), 32'h0);
				look(p, int'($urandom() % 32));
			end
		// unmapped and misaligned places
		foreach (bad[b])
		begin
			apb(1'b1, bad[b], $urandom());
			apb(1'b0, bad[b], 32'h0);
			apb(1'b0, bad[b] & 8'h7c, 32'h0);
		end
		restart();
		end_sim();
	end
endmodule : tb_pmx_port_mux
